// file: hdl/access_window_timer.sv
// Timed access window opened by the enable password.
`include "rtc_guard_map.svh"

module access_window_timer (
    // Clock and reset.
    input  wire logic core_clk_in,
    input  wire logic sys_rst_in,
    // Password events.
    input  wire logic open_req_in,
    input  wire logic close_req_in,
    // Window state.
    output logic      access_open_flag_out
);

    // Cycles left in the open window.
    logic [9:0] remaining;

    // A matching password (re)starts a full window; any other value or
    // the end of the count shuts it.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            access_open_flag_out <= 1'b0;
            remaining            <= 10'h000;
        end else if (close_req_in) begin
            access_open_flag_out <= 1'b0;
            remaining            <= 10'h000;
        end else if (open_req_in) begin
            access_open_flag_out <= 1'b1;
            remaining            <= `WINDOW_CYCLES - 10'h001;
        end else if (access_open_flag_out) begin
            if (remaining == 10'h000) begin
                access_open_flag_out <= 1'b0;
            end else begin
                remaining <= remaining - 10'h001;
            end
        end
    end

endmodule

// file: hdl/rtc_guard_map.svh
// Register offsets, keys, reset values and counts of the clock access guard.
`ifndef RTC_GUARD_MAP_SVH
`define RTC_GUARD_MAP_SVH

// Byte offsets on the register bus.
`define OFS_INIT_KEY      8'h00
`define OFS_ACCESS_PW     8'h04
`define OFS_FIRST_CLK     8'h08
`define OFS_LAST_CLK      8'h30

// Index of each clock register inside the stored array.
`define IDX_FREQ_TRIM     4'h0
`define IDX_TIME_VALUE    4'h1
`define IDX_CAL_VALUE     4'h2
`define IDX_HOUR_SCALE    4'h3
`define IDX_WEEKDAY       4'h4
`define IDX_ALARM_TIME    4'h5
`define IDX_ALARM_CAL     4'h6
`define IDX_LEAP_YEAR     4'h7
`define IDX_IRQ_ENABLE    4'h8
`define IDX_IRQ_IND       4'h9
`define IDX_TICK_PERIOD   4'ha
`define NUM_CLK_REGS      11

// Reset values loaded into the clock registers by the start key.
`define RST_FREQ_TRIM     32'h0000_0700
`define RST_CAL_VALUE     32'h0005_0101
`define RST_HOUR_SCALE    32'h0000_0001
`define RST_WEEKDAY       32'h0000_0006
`define RST_ZERO          32'h0000_0000

// Keys, field positions and counts.
`define INIT_KEY          32'ha5eb_1357
`define ENABLE_PASSWORD   16'ha965
`define ACTIVE_BIT        0
`define OPEN_FLAG_BIT     16
`define PW_MSB            15
`define IRQ_IND_MSB       1
`define WINDOW_CYCLES     10'h200
`define WRITE_LAG_STAGES  2
`define ALL_LANES         4'hf

`endif

// file: hdl/rtc_guard_pkg.sv
// Types shared by the clock access guard modules.
package rtc_guard_pkg;

    // One write on its way into a clock register.
    typedef struct packed {
        logic        valid;   // A write is carried in this slot.
        logic [3:0]  idx;     // Target clock register index.
        logic [31:0] data;    // Merged value to be stored.
    } wr_req_t;

    // Full image of the eleven clock registers.
    typedef logic [10:0][31:0] clock_regs_t;

    // What software may do with a clock register right now.
    typedef enum {
        ACC_FULL,
        ACC_READ,
        ACC_NONE,
        ACC_READ_CLEAR
    } access_class_t;

    // Bus answer sequencing for reads.
    typedef enum {
        BUS_IDLE,
        BUS_READ_DONE
    } bus_state_t;

endpackage

// file: hdl/rtc_init_and_access_guard.sv
// Start-key and password guard for the calendar clock register bank.
// Chip reset stops the clock logic but leaves the stored clock
// registers as they are; only the start key reloads them.
// Reads cost one wait state since the answer comes from a flip-flop.
// A read right after a write may still return the old value.
// The window counts cycles of this clock, whatever the bus does.
// Only the two low bytes of the access register form the password.
// Writes to refused registers are dropped without any error.
// There is no interrupt output; the indicator is only a register.
`include "rtc_guard_map.svh"

module rtc_init_and_access_guard (
    // Clock and reset.
    input  wire logic                 core_clk_in,
    input  wire logic                 sys_rst_in,
    // Avalon-MM slave.
    input  wire logic [7:0]           avs_address_in,
    input  wire logic                 avs_read_in,
    input  wire logic                 avs_write_in,
    input  wire logic [31:0]          avs_writedata_in,
    input  wire logic [3:0]           avs_byteenable_in,
    output logic [31:0]               avs_readdata_out,
    output logic                      avs_waitrequest_out,
    // Events from the clock counters.
    input  wire logic                 leap_year_in,
    input  wire logic [1:0]           irq_event_in,
    // Block state.
    output logic                      clock_active_out,
    output logic                      access_open_flag_out,
    output rtc_guard_pkg::clock_regs_t clock_regs_out
);

    // Eleven words are kept in flip-flops; a memory would cost a
    // read cycle and buy nothing at this size.
    // Stored clock registers; hold no value until the start key arrives.
    logic [31:0] clk_reg [`NUM_CLK_REGS];
    // Clock logic running flag.
    logic        active;
    // Read answer sequencing.
    rtc_guard_pkg::bus_state_t bus_state;
    // Index and class of the addressed clock register.
    logic [3:0]  addr_idx;
    logic        addr_is_clk;
    rtc_guard_pkg::access_class_t addr_class;
    // Accepted write, merged with byte lanes.
    logic        wr_take;
    logic [31:0] wr_merged;
    // Write entering and leaving the lag line.
    rtc_guard_pkg::wr_req_t lag_in;
    rtc_guard_pkg::wr_req_t lag_out;
    // Start key accepted this cycle.
    logic        init_fire;
    // Password events.
    logic        pw_write;
    logic        pw_match;
    // Read of the interrupt indicator completing this cycle.
    logic        ind_read_done;
    // Bits of the indicator that the completing read returned.
    logic [31:0] ind_seen;

    // Maps a byte address to a clock register index.
    // Only meaningful inside the clock range; callers qualify it.
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - `OFS_FIRST_CLK;
        reg_index = rel[5:2];
    endfunction

    // Tells what software may do with a clock register in the given window.
    function automatic rtc_guard_pkg::access_class_t class_of(
        input logic [3:0] idx,
        input logic       open
    );
        class_of = rtc_guard_pkg::ACC_FULL;
        // Leap and indicator classes never depend on the window.
        if (idx == `IDX_LEAP_YEAR) begin
            class_of = rtc_guard_pkg::ACC_READ;
        end else if (idx == `IDX_IRQ_IND) begin
            class_of = rtc_guard_pkg::ACC_READ_CLEAR;
        end else if (open) begin
            class_of = rtc_guard_pkg::ACC_FULL;
        end else if (idx == `IDX_TIME_VALUE || idx == `IDX_CAL_VALUE ||
                     idx == `IDX_WEEKDAY) begin
            class_of = rtc_guard_pkg::ACC_READ;
        end else if (idx == `IDX_HOUR_SCALE || idx == `IDX_IRQ_ENABLE) begin
            class_of = rtc_guard_pkg::ACC_FULL;
        end else begin
            class_of = rtc_guard_pkg::ACC_NONE;
        end
    endfunction

    // Merges write data into an old value under the byte enables.
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  lanes
    );
        logic [31:0] mask;
        // Disabled lanes keep the stored byte, so one field can be
        // updated without reading the word first.
        mask = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
        lane_merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    // Address decode; the aligned range between the first and last clock
    // registers is mapped, everything else but the init and access registers reads zero and drops writes.
    // Misaligned addresses are refused so that a byte address inside one
    // register never aliases onto its neighbour.
    always_comb begin
        addr_idx    = reg_index(avs_address_in);
        addr_is_clk = 1'b0;
        if (avs_address_in[1:0] != 2'h0) begin
            addr_is_clk = 1'b0;
        end else if (avs_address_in >= `OFS_FIRST_CLK &&
                     avs_address_in <= `OFS_LAST_CLK) begin
            addr_is_clk = 1'b1;
        end
        addr_class = class_of(addr_idx, access_open_flag_out);
    end

    // Writes never wait; reads wait one cycle so the answer is registered.
    // The stall depends on the read itself, so idle cycles never stall
    // and a read held past its answer simply starts a new transfer.
    assign avs_waitrequest_out = avs_read_in &&
                                 (bus_state == rtc_guard_pkg::BUS_IDLE);

    // A write is taken in the cycle it is presented.
    // Hazard: the merge uses the stored word, so a partial write that
    // follows another write to the same register within two cycles
    // merges with the stale value; software should space such writes.
    assign wr_take   = avs_write_in && !avs_read_in;
    assign wr_merged = lane_merge(addr_is_clk ? clk_reg[addr_idx] : `RST_ZERO,
                                  avs_writedata_in, avs_byteenable_in);

    // The start key counts only as a full word while the clock is stopped.
    // Demanding all four lanes keeps a byte write whose low byte happens
    // to match from starting the clock by accident.
    assign init_fire = wr_take && (avs_address_in == `OFS_INIT_KEY) &&
                       !active &&
                       (avs_byteenable_in == `ALL_LANES) &&
                       (avs_writedata_in == `INIT_KEY);

    // Password writes; a partial write of the field is treated as a miss.
    // The upper half of the written word is ignored; reads show the flag
    // there instead.
    assign pw_write = wr_take && (avs_address_in == `OFS_ACCESS_PW);
    assign pw_match = (avs_byteenable_in[1:0] == 2'h3) &&
                      (avs_writedata_in[`PW_MSB:0] == `ENABLE_PASSWORD);

    // Only writes that the current window allows enter the lag line, and
    // only while the clock logic runs, since before that nothing is kept.
    // Leap and indicator writes never qualify, as their class is never
    // full access.
    always_comb begin
        lag_in       = '0;
        lag_in.idx   = addr_idx;
        lag_in.data  = wr_merged;
        lag_in.valid = wr_take && addr_is_clk && active &&
                       (addr_class == rtc_guard_pkg::ACC_FULL);
    end

    // Writes reach the stored registers two cycles after acceptance, which
    // keeps the old value visible to reads in between.
    // The lag stands in for the crossing into the slow counter clock,
    // so software meets the same delay as with a true crossing.
    write_lag_pipe u_write_lag (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .req_in      (lag_in),
        .req_out     (lag_out)
    );

    // Timed access window driven by the password field.
    // Any write to the access register either restarts or ends the
    // window; no write leaves it alone.
    access_window_timer u_window (
        .core_clk_in          (core_clk_in),
        .sys_rst_in           (sys_rst_in),
        .open_req_in          (pw_write && pw_match),
        .close_req_in         (pw_write && !pw_match),
        .access_open_flag_out (access_open_flag_out)
    );

    // Running flag: chip reset stops the clock logic, the start key starts
    // it, and once running the init register no longer reacts.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            active <= 1'b0;
        end else if (init_fire) begin
            active <= 1'b1;
        end
    end

    // The running flag leaves the block as a plain level.
    assign clock_active_out = active;

    // A completing read of the indicator clears the bits it returned.
    // Clearing only what was returned keeps an event that arrives between
    // capture and completion from being lost.
    assign ind_read_done = avs_read_in &&
                           (bus_state == rtc_guard_pkg::BUS_READ_DONE) &&
                           addr_is_clk && (addr_idx == `IDX_IRQ_IND);
    assign ind_seen      = ind_read_done ? avs_readdata_out : `RST_ZERO;

    // Clock register storage. Chip reset deliberately leaves it alone: the
    // counters keep their own reset, which is the start key.
    always_ff @(posedge core_clk_in) begin
        if (init_fire) begin
            for (int i = 0; i < `NUM_CLK_REGS; i++) begin
                clk_reg[i] <= `RST_ZERO;
            end
            clk_reg[`IDX_FREQ_TRIM]  <= `RST_FREQ_TRIM;
            clk_reg[`IDX_CAL_VALUE]  <= `RST_CAL_VALUE;
            clk_reg[`IDX_HOUR_SCALE] <= `RST_HOUR_SCALE;
            clk_reg[`IDX_WEEKDAY]    <= `RST_WEEKDAY;
        end else if (active) begin
            // Events from the counters are only kept while the clock runs.
            // A landed write updates its register.
            if (lag_out.valid) begin
                clk_reg[lag_out.idx] <= lag_out.data;
            end
            // Leap indication follows the calendar counters only.
            clk_reg[`IDX_LEAP_YEAR] <= {31'h0000_0000, leap_year_in};
            // New events win over a clear in the same cycle.
            clk_reg[`IDX_IRQ_IND] <= (clk_reg[`IDX_IRQ_IND] & ~ind_seen) |
                                     {30'h0000_0000, irq_event_in};
        end
    end

    // Read answer sequencing: capture in the first cycle, answer in the
    // second, then return to idle.
    // A master that keeps read high past the answer is seen as making
    // a fresh request, so no state can stick in the answer cycle.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bus_state <= rtc_guard_pkg::BUS_IDLE;
        end else begin
            case (bus_state)
                rtc_guard_pkg::BUS_IDLE: begin
                    if (avs_read_in) begin
                        bus_state <= rtc_guard_pkg::BUS_READ_DONE;
                    end
                end
                rtc_guard_pkg::BUS_READ_DONE: begin
                    bus_state <= rtc_guard_pkg::BUS_IDLE;
                end
                default: begin
                    bus_state <= rtc_guard_pkg::BUS_IDLE;
                end
            endcase
        end
    end

    // Read data register; filled in the capture cycle and held otherwise.
    // Unmapped, blocked or stopped registers read zero rather than
    // raising an error, so probing the map never hangs the bus.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            avs_readdata_out <= `RST_ZERO;
        end else if (avs_read_in &&
                     bus_state == rtc_guard_pkg::BUS_IDLE) begin
            avs_readdata_out <= `RST_ZERO;
            if (avs_address_in == `OFS_INIT_KEY) begin
                // Only the running flag is visible.
                avs_readdata_out[`ACTIVE_BIT] <= active;
            end else if (avs_address_in == `OFS_ACCESS_PW) begin
                // Password field reads zero; only the flag shows.
                avs_readdata_out[`OPEN_FLAG_BIT] <=
                    access_open_flag_out;
            end else if (addr_is_clk && active &&
                         addr_class != rtc_guard_pkg::ACC_NONE) begin
                avs_readdata_out <= clk_reg[addr_idx];
            end
        end
    end

    // Clock register image for the counters; zero while stopped so no
    // unknown value leaves the block.
    // Registering the image adds one cycle towards the counters on top
    // of the write lag, but keeps their inputs free of decode glitches.
    generate
        for (genvar r = 0; r < `NUM_CLK_REGS; r = r + 1) begin : g_out
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in || !active) begin
                    clock_regs_out[r] <= `RST_ZERO;
                end else begin
                    clock_regs_out[r] <= clk_reg[r];
                end
            end
        end
    endgenerate

endmodule

// file: hdl/write_lag_pipe.sv
// Delay line that lands clock-register writes a fixed number of cycles late.
`include "rtc_guard_map.svh"

module write_lag_pipe (
    // Clock and reset.
    input  wire logic                   core_clk_in,
    input  wire logic                   sys_rst_in,
    // Write entering the line.
    input  wire rtc_guard_pkg::wr_req_t req_in,
    // Write leaving the line.
    output rtc_guard_pkg::wr_req_t      req_out
);

    // One slot per stage of lag.
    rtc_guard_pkg::wr_req_t stage [`WRITE_LAG_STAGES];

    // Each stage takes the previous one; the first takes the new write.
    genvar g;
    generate
        for (g = 0; g < `WRITE_LAG_STAGES; g = g + 1) begin : g_stage
            always_ff @(posedge core_clk_in) begin
                if (sys_rst_in) begin
                    stage[g] <= '0;
                end else if (g == 0) begin
                    stage[g] <= req_in;
                end else begin
                    stage[g] <= stage[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    // The last stage is the write that now takes effect.
    assign req_out = stage[`WRITE_LAG_STAGES - 1];

endmodule

// file: tb/rtc_guard_asserts.sv
// Port-level checks of the clock start-key and access guard.
`include "rtc_guard_map.svh"
module rtc_guard_checker (
    // Clock and reset.
    input wire logic                       core_clk_in,
    input wire logic                       sys_rst_in,
    // Register bus.
    input wire logic [7:0]                 avs_address_in,
    input wire logic                       avs_read_in,
    input wire logic                       avs_write_in,
    input wire logic [31:0]                avs_writedata_in,
    input wire logic [3:0]                 avs_byteenable_in,
    input wire logic                       avs_waitrequest_out,
    // Block state.
    input wire logic                       clock_active_out,
    input wire logic                       access_open_flag_out,
    input wire rtc_guard_pkg::clock_regs_t clock_regs_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // A write counts only when no read rides with it.
    wire logic       wr_ok = avs_write_in && !avs_read_in;
    wire logic       pw_wr = wr_ok && avs_address_in == `OFS_ACCESS_PW;
    // Password matches only with both low lanes enabled.
    wire logic       pw_hit = avs_byteenable_in[1:0] == 2'h3
                              && avs_writedata_in[15:0] == `ENABLE_PASSWORD;
    wire logic       key_wr = wr_ok && avs_address_in == `OFS_INIT_KEY
                              && avs_byteenable_in == `ALL_LANES
                              && avs_writedata_in == `INIT_KEY;
    wire logic [1:0] wd_lo = avs_writedata_in[1:0];
    // Cycles since a password was accepted while running; zero before that and after other password writes; it keeps counting past a timeout.
    logic [9:0]      win_cnt;

    // Window age counter; it saturates so a long idle never wraps to zero.
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            win_cnt <= 10'h000;
        end else if (pw_wr && pw_hit && clock_active_out) begin
            win_cnt <= 10'h001;
        end else if (pw_wr) begin
            win_cnt <= 10'h000;
        end else if (win_cnt != 10'h000 && win_cnt != 10'h3ff) begin
            win_cnt <= win_cnt + 10'h001;
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_write_no_wait: assert property (wr_ok |-> !avs_waitrequest_out)
        else $error("write was stalled");
    a_read_one_wait: assert property ($rose(avs_read_in)
        |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("read did not finish after one wait state");
    a_key_starts: assert property (
        !clock_active_out && key_wr |=> clock_active_out)
        else $error("start key did not start the clock");
    a_active_holds: assert property (
        clock_active_out |=> clock_active_out)
        else $error("running flag dropped after start");
    a_idle_regs_zero: assert property (
        !clock_active_out |-> clock_regs_out == '0)
        else $error("clock registers not zero before start");
    a_pw_opens: assert property (
        pw_wr && pw_hit && clock_active_out |=> access_open_flag_out)
        else $error("password did not open the window");
    a_pw_closes: assert property (
        pw_wr && !pw_hit |=> !access_open_flag_out)
        else $error("wrong password left the window open");
    a_window_held: assert property (
        win_cnt != 10'h000 && win_cnt <= 10'h200 |-> access_open_flag_out)
        else $error("window closed early");
    a_window_ends: assert property (
        win_cnt == 10'h201 |-> !access_open_flag_out)
        else $error("window stayed open too long");
    a_write_lag: assert property (
        wr_ok && clock_active_out && avs_address_in == 8'h28
        && avs_byteenable_in == `ALL_LANES
        |-> ##4 clock_regs_out[`IDX_IRQ_ENABLE][1:0] == $past(wd_lo, 4))
        else $error("enable register write did not land on time");
endmodule

bind rtc_init_and_access_guard rtc_guard_checker chk_u (
    .core_clk_in          (core_clk_in),
    .sys_rst_in           (sys_rst_in),
    .avs_address_in       (avs_address_in),
    .avs_read_in          (avs_read_in),
    .avs_write_in         (avs_write_in),
    .avs_writedata_in     (avs_writedata_in),
    .avs_byteenable_in    (avs_byteenable_in),
    .avs_waitrequest_out  (avs_waitrequest_out),
    .clock_active_out     (clock_active_out),
    .access_open_flag_out (access_open_flag_out),
    .clock_regs_out       (clock_regs_out)
);

// file: tb/rtc_init_and_access_guard_test.sv
// Self-checking bench for the clock start-key and access guard.
`include "rtc_guard_map.svh"
module rtc_init_and_access_guard_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus, all given a value at time zero.
    logic        core_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [7:0]  avs_address_in = 8'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'h0;
    logic        leap_year_in = 1'b0;
    logic [1:0]  irq_event_in = 2'h0;
    // Design outputs.
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        clock_active_out;
    logic        access_open_flag_out;
    rtc_guard_pkg::clock_regs_t clock_regs_out;
    // Tallies and scratch.
    int          fails = 0;
    int          compares = 0;
    int          n;
    logic [31:0] got;
    // Reads expected right after start, window closed (trim is blocked).
    logic [31:0] closed_img [11] = '{`RST_ZERO, `RST_ZERO, `RST_CAL_VALUE,
        `RST_HOUR_SCALE, `RST_WEEKDAY, `RST_ZERO, `RST_ZERO, `RST_ZERO,
        `RST_ZERO, `RST_ZERO, `RST_ZERO};

    // Free-running 100 MHz clock.
    always #5 core_clk_in = ~core_clk_in;

    rtc_init_and_access_guard dut_u (
        .core_clk_in          (core_clk_in),
        .sys_rst_in           (sys_rst_in),
        .avs_address_in       (avs_address_in),
        .avs_read_in          (avs_read_in),
        .avs_write_in         (avs_write_in),
        .avs_writedata_in     (avs_writedata_in),
        .avs_byteenable_in    (avs_byteenable_in),
        .avs_readdata_out     (avs_readdata_out),
        .avs_waitrequest_out  (avs_waitrequest_out),
        .leap_year_in         (leap_year_in),
        .irq_event_in         (irq_event_in),
        .clock_active_out     (clock_active_out),
        .access_open_flag_out (access_open_flag_out),
        .clock_regs_out       (clock_regs_out)
    );

    // Compare one value and tally it.
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus transfer, entered just after a rising edge. Signals are held
    // until the edge where waitrequest is low; the idle edge at the end
    // keeps two transfers from driving one signal in the same time step.
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] data, input logic [3:0] lanes);
        logic stall;
        int   tries;
        tries = 0;
        avs_address_in <= addr;
        avs_writedata_in <= data;
        avs_byteenable_in <= lanes;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            // Values read here are those that the rising edge itself saw.
            @(posedge core_clk_in);
            tries++;
            stall = avs_waitrequest_out;
            got = avs_readdata_out;
        end while (stall && tries < 20);
        check("waitrequest", 32'h0, {31'h0, stall});
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    // Full-word write; the pause lets the two-cycle write lag land first.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, `ALL_LANES);
        repeat (3) @(posedge core_clk_in);
    endtask

    // Read and compare.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, `ALL_LANES);
        check($sformatf("read at %h", a), exp, got);
    endtask

    // Verdict and end of run.
    task automatic report_and_stop();
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the fewer than a thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge core_clk_in);
        fails++;
        report_and_stop();
    end

    // Test sequence.
    initial begin
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(`OFS_INIT_KEY, 32'h0);
        wr(8'h28, 32'h3);
        rd(8'h28, 32'h0);
        wr(`OFS_INIT_KEY, 32'h1234_5678);
        xfer(1'b1, `OFS_INIT_KEY, `INIT_KEY, 4'h7);
        rd(`OFS_INIT_KEY, 32'h0);
        wr(`OFS_INIT_KEY, `INIT_KEY);
        rd(`OFS_INIT_KEY, 32'h1);
        for (int i = 0; i < `NUM_CLK_REGS; i++) begin
            rd(8'(`OFS_FIRST_CLK + 4 * i), closed_img[i]);
        end
        // Closed window: read-only, blocked and free registers.
        wr(8'h0c, 32'h0012_3456);
        wr(8'h1c, 32'h11);
        wr(8'h14, 32'h0);
        wr(8'h28, 32'h3);
        rd(8'h0c, 32'h0);
        rd(8'h14, 32'h0);
        rd(8'h28, 32'h3);
        wr(`OFS_INIT_KEY, `INIT_KEY);
        rd(8'h14, 32'h0);
        rd(8'h40, 32'h0);
        // Leap level and one indicator event from the counters.
        leap_year_in <= 1'b1;
        irq_event_in <= 2'h2;
        @(posedge core_clk_in);
        irq_event_in <= 2'h0;
        wr(8'h24, 32'h0);
        rd(8'h24, 32'h1);
        rd(8'h2c, 32'h2);
        rd(8'h2c, 32'h0);
        // Open window.
        wr(`OFS_ACCESS_PW, 32'h0000_a965);
        rd(`OFS_ACCESS_PW, 32'h0001_0000);
        rd(8'h08, `RST_FREQ_TRIM);
        rd(8'h1c, 32'h0);
        wr(8'h0c, 32'h0012_3456);
        rd(8'h0c, 32'h0012_3456);
        wr(`OFS_ACCESS_PW, 32'h0000_1234);
        rd(`OFS_ACCESS_PW, 32'h0);
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h0012_3456);
        rd(8'h08, 32'h0);
        // The first window cycle passes inside the transfer task.
        xfer(1'b1, `OFS_ACCESS_PW, 32'h0000_a965, `ALL_LANES);
        n = 0;
        repeat (600) begin
            @(negedge core_clk_in);
            if (access_open_flag_out === 1'b1) n++;
        end
        check("window", 32'(`WINDOW_CYCLES - 1), 32'(n));
        @(posedge core_clk_in);
        rd(`OFS_ACCESS_PW, 32'h0);
        // Chip reset stops the clock; only a new key reloads the registers.
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        rd(`OFS_INIT_KEY, 32'h0);
        rd(8'h14, 32'h0);
        wr(`OFS_INIT_KEY, `INIT_KEY);
        rd(8'h14, `RST_HOUR_SCALE);
        report_and_stop();
    end
endmodule
